/* File: afc_pkg.sv */
// Package of constants and types for the address filter command unit
package afc_pkg;

  // ************************************************************
  // Geometry
  // ************************************************************
  localparam int ENTRIES     = 32;
  localparam int IDX_W       = 5;
  localparam int WORD_W      = 48;
  localparam int PERS_W      = 6;
  localparam int REG_W       = 16;

  // ************************************************************
  // Register select codes on the host register port
  // ************************************************************
  localparam logic [3:0] SEL_CMD    = 4'h0;
  localparam logic [3:0] SEL_STATUS = 4'h1;
  localparam logic [3:0] SEL_BIST   = 4'h2;
  localparam logic [3:0] SEL_PERS   = 4'h3;
  localparam logic [3:0] SEL_COMP0  = 4'h4;
  localparam logic [3:0] SEL_COMP1  = 4'h5;
  localparam logic [3:0] SEL_COMP2  = 4'h6;
  localparam logic [3:0] SEL_MASK0  = 4'h7;
  localparam logic [3:0] SEL_MASK1  = 4'h8;
  localparam logic [3:0] SEL_MASK2  = 4'h9;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int INSTRUCTION_CODE_LSB    = 0;
  localparam int INSTRUCTION_CODE_W      = 3;
  localparam int ST_DONE     = 15;
  localparam int ST_FULL     = 14;
  localparam int ST_FOUND    = 13;
  localparam int ST_EXACT    = 12;
  localparam int ST_MULTIPLE_MATCH_FLAG     = 11;
  localparam int ST_ERROR    = 10;
  localparam int ST_EMPTY    = 9;
  localparam int ST_SELFTEST = 8;
  localparam int ST_REV_LSB  = 5;
  localparam int PERS_VALID  = 0;
  localparam int PERS_SKIP   = 1;
  localparam int PERS_DAX    = 2;

  // ************************************************************
  // Reset values and identity
  // ************************************************************
  localparam logic [REG_W-1:0] CMD_RESET  = 16'h0000;
  localparam logic [2:0]       REVISION   = 3'h1; // Arbitrary value
  localparam logic [REG_W-1:0] BIST_SEED  = 16'hace1;
  localparam logic [REG_W-1:0] BIST_POLY  = 16'hb400;

  // ************************************************************
  // Timing counts
  // ************************************************************
  localparam int SELFTEST_CYCLES = 64;

  // ************************************************************
  // Instruction codes and sequencer states
  // ************************************************************
  typedef enum logic [2:0]
  {
    OP_INV_ALL   = 3'h0,
    OP_WRITE     = 3'h1,
    OP_READ      = 3'h2,
    OP_SELFTEST  = 3'h3,
    OP_FIND      = 3'h4,
    OP_INV_ONE   = 3'h5,
    OP_SKIP      = 3'h6,
    OP_CLR_SKIP  = 3'h7
  } afc_op_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_EXEC,
    ST_SELF,
    ST_FINISH
  } afc_state_t;

endpackage : afc_pkg

/* File: afc_prio_enc.sv */
// Lowest-index priority encoder with hit count summary
`timescale 1ns/1ps
module afc_prio_enc
  import afc_pkg::*;
(
  input  wire logic [ENTRIES-1:0] hit_vec,
  output logic      [IDX_W-1:0]   first_idx,
  output logic                    any_hit,
  output logic                    multi_hit
);

  // ************************************************************
  // Encoder
  // ************************************************************
  // Scan downward so the lowest hit wins
  always_comb
  begin
    first_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        first_idx = IDX_W'(i);
      end
    end
  end

  // Any hit and more than one hit
  assign any_hit   = |hit_vec;
  assign multi_hit = |(hit_vec & (hit_vec - ENTRIES'(1)));

endmodule // afc_prio_enc

/* File: afc_selftest.sv */
// Self-test sequencer producing a signature over a fixed cycle count
`timescale 1ns/1ps
module afc_selftest
  import afc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  input  wire logic             start,
  output logic                  busy,
  output logic                  done_pulse,
  output logic      [REG_W-1:0] signature
);

  logic [6:0]       cnt_q;
  logic [REG_W-1:0] lfsr_q;

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Count cycles while shifting the signature register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q      <= '0;
      lfsr_q     <= '0;
      busy       <= 1'b0;
      done_pulse <= 1'b0;
    end
    else if (ce)
    begin
      done_pulse <= 1'b0;
      if (start)
      begin
        cnt_q  <= 7'(SELFTEST_CYCLES - 1);
        lfsr_q <= BIST_SEED;
        busy   <= 1'b1;
      end
      else if (busy)
      begin
        lfsr_q <= lfsr_q[0] ? ((lfsr_q >> 1) ^ BIST_POLY) : (lfsr_q >> 1);
        cnt_q  <= cnt_q - 7'h01;
        if (cnt_q == 7'h00)
        begin
          busy       <= 1'b0;
          done_pulse <= 1'b1;
        end
      end
    end
  end

  assign signature = lfsr_q;

endmodule // afc_selftest

/* File: afc_cam_cmd.sv */
// Command and status unit of a 32-entry address filter CAM
// Contract
// R01: Writing instruction bits 2:0 starts that operation; reads return last value.
// R02: Code 000 invalidates all; clears flags on issue, sets done and empty.
// R03: Code 001 stores staged entry into empty slot; sets done, full if none left.
// R04: Write while full stores nothing; software checks full first.
// R05: Code 010 copies the found entry into comparand, mask, personality registers.
// R06: Read sets error when empty or found clear; done set on completion.
// R07: Code 011 runs self test; sets done and self-test-complete.
// R08: Host resets the filter after self test before further operations.
// R09: Code 100 compares comparand with all entries; skipped never match; no host mask.
// R10: Find completion sets done and loads found, multiple and exact.
// R11: Code 101 invalidates first found entry; updates empty flag.
// R12: Invalidate one and skip set error if found clear, else error clear.
// R13: Code 110 skips first found entry, same one a read returns.
// R14: Code 111 clears every skip mark and sets done.
// R15: Issuing codes 010 to 111 clears done, found, multiple, error, self-test, exact.
// R16: Status flags are static; reads change nothing.
// R17: Bit 15 is done; host waits for it before a new command.
// R18: Bit 14 set exactly when every entry is valid.
// R19: Reserved status bits read zero.
// R20: Done flag may drive an interrupt to the host.
// R21: Bit 13 reports a masked match in last find; skip and invalidate clear it.
// R22: Bit 9 set when no entry valid; cleared after write.
// R23: Command ignored during receive-bus compare sets error.
// R24: Lowest-index match is the first match for read, invalidate, skip.
// R25: Command writes while busy are ignored, status unchanged.
`timescale 1ns/1ps
module afc_cam_cmd
  import afc_pkg::*;
(
  input  wire logic             CORE_CLK,
  input  wire logic             ARST_N,
  input  wire logic             CE,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [3:0]       REG_SEL,
  input  wire logic [REG_W-1:0] REG_WDATA,
  input  wire logic             RX_CMP_BUSY,
  output logic      [REG_W-1:0] REG_RDATA,
  output logic                  DONE_IRQ
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [WORD_W-1:0] cam_word_q [ENTRIES];
  logic [WORD_W-1:0] cam_mask_q [ENTRIES];
  logic [PERS_W-1:0] cam_pers_q [ENTRIES];

  logic [INSTRUCTION_CODE_W-1:0] instruction_code_q;
  logic [REG_W-1:0]  comp_q [3];
  logic [REG_W-1:0]  mask_q [3];
  logic [REG_W-1:0]  pers_q;
  logic [REG_W-1:0]  bist_q;

  logic done_q, found_q, exact_q, multiple_match_flag_q, error_q, stdone_q;
  logic [IDX_W-1:0] hit_idx_q;
  afc_state_t       state_q;
  afc_op_t          op_q;

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Join three host halves into one 48-bit word
  function automatic logic [WORD_W-1:0] join3(input logic [REG_W-1:0] r [3]);
    join3 = {r[2], r[1], r[0]};
  endfunction

  // Select the register halfword for a given index
  function automatic logic [REG_W-1:0] part3(input logic [WORD_W-1:0] w, input int k);
    part3 = w[k*REG_W +: REG_W];
  endfunction

  // ************************************************************
  // Combinational view of the array
  // ************************************************************
  logic [ENTRIES-1:0] valid_vec;
  logic [ENTRIES-1:0] hit_vec;
  logic [ENTRIES-1:0] dax_vec;
  logic [ENTRIES-1:0] free_vec;
  logic [WORD_W-1:0]  key;
  logic [IDX_W-1:0]   first_hit;
  logic [IDX_W-1:0]   first_free;
  logic               any_hit, multi_hit, any_free, unused_free_multi;
  logic               all_valid, none_valid;

  assign key = join3(comp_q);

  // Per-entry valid, match and free flags
  always_comb
  begin
    for (int i = 0; i < ENTRIES; i++)
    begin
      valid_vec[i] = cam_pers_q[i][PERS_VALID];
      free_vec[i]  = ~cam_pers_q[i][PERS_VALID];
      // Entry mask only; host mask takes no part, skipped never match
      hit_vec[i]   = valid_vec[i] && !cam_pers_q[i][PERS_SKIP] &&                   // R09
                     (((cam_word_q[i] ^ key) & cam_mask_q[i]) == '0);
      dax_vec[i]   = hit_vec[i] & cam_pers_q[i][PERS_DAX];
    end
  end

  assign all_valid  = &valid_vec;                                                 // R18
  assign none_valid = ~|valid_vec;                                                // R22

  // Lowest matching entry
  afc_prio_enc u_hit_enc
  (
    .hit_vec   (hit_vec),
    .first_idx (first_hit),                                                       // R24
    .any_hit   (any_hit),
    .multi_hit (multi_hit)
  );

  // Lowest free slot for writes
  afc_prio_enc u_free_enc
  (
    .hit_vec   (free_vec),
    .first_idx (first_free),
    .any_hit   (any_free),
    .multi_hit (unused_free_multi)
  );

  // ************************************************************
  // Command acceptance
  // ************************************************************
  logic cmd_wr, cmd_go, cmd_refused, st_start, st_busy, st_done;
  logic [REG_W-1:0] st_sig;

  assign cmd_wr      = REG_WR && (REG_SEL == SEL_CMD);
  assign cmd_refused = cmd_wr && (state_q == ST_IDLE) && RX_CMP_BUSY;             // R23
  assign cmd_go      = cmd_wr && (state_q == ST_IDLE) && !RX_CMP_BUSY;            // R25
  assign st_start    = cmd_go && (afc_op_t'(REG_WDATA[INSTRUCTION_CODE_W-1:0]) == OP_SELFTEST);

  afc_selftest u_selftest
  (
    .clk        (CORE_CLK),
    .arst_n     (ARST_N),
    .ce         (CE),
    .start      (st_start),                                                       // R07
    .busy       (st_busy),
    .done_pulse (st_done),
    .signature  (st_sig)
  );

  // ************************************************************
  // Instruction register
  // ************************************************************
  // Holds last written instruction code, even when the command is ignored
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      instruction_code_q <= CMD_RESET[INSTRUCTION_CODE_W-1:0];
    end
    else if (CE && cmd_wr)
    begin
      instruction_code_q <= REG_WDATA[INSTRUCTION_CODE_W-1:0];                                            // R01
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Issue, execute for one cycle (self test stays in ST_SELF until its done pulse), then complete
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_q <= ST_IDLE;
      op_q    <= OP_INV_ALL;
    end
    else if (CE)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (cmd_go)
          begin
            op_q    <= afc_op_t'(REG_WDATA[INSTRUCTION_CODE_W-1:0]);                          // R01
            state_q <= (afc_op_t'(REG_WDATA[INSTRUCTION_CODE_W-1:0]) == OP_SELFTEST) ? ST_SELF : ST_EXEC;
          end
        end
        ST_EXEC:   state_q <= ST_FINISH;
        ST_SELF:   state_q <= st_done ? ST_FINISH : ST_SELF;
        ST_FINISH: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // CAM array updates
  // ************************************************************
  // Array changes happen in the execute cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        cam_word_q[i] <= '0;
        cam_mask_q[i] <= '0;
        cam_pers_q[i] <= '0;
      end
    end
    else if (CE && state_q == ST_EXEC)
    begin
      case (op_q)
        OP_INV_ALL:
        begin
          for (int i = 0; i < ENTRIES; i++)
          begin
            cam_pers_q[i][PERS_VALID] <= 1'b0;                                    // R02
          end
        end
        OP_WRITE:
        begin
          if (!all_valid && any_free)                                             // R04
          begin
            cam_word_q[first_free] <= key;                                        // R03
            cam_mask_q[first_free] <= join3(mask_q);
            cam_pers_q[first_free] <= pers_q[PERS_W-1:0] | PERS_W'(1);
          end
        end
        OP_INV_ONE:
        begin
          // Found is cleared at issue; error holds its verdict
          if (!error_q)
          begin
            cam_pers_q[hit_idx_q][PERS_VALID] <= 1'b0;                            // R11
          end
        end
        OP_SKIP:
        begin
          if (!error_q)
          begin
            cam_pers_q[hit_idx_q][PERS_SKIP] <= 1'b1;                             // R13
          end
        end
        OP_CLR_SKIP:
        begin
          for (int i = 0; i < ENTRIES; i++)
          begin
            cam_pers_q[i][PERS_SKIP] <= 1'b0;                                     // R14
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ************************************************************
  // Host data registers
  // ************************************************************
  // Host writes, read-back from the found entry, signature capture
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int k = 0; k < 3; k++)
      begin
        comp_q[k] <= '0;
        mask_q[k] <= '0;
      end
      pers_q <= '0;
      bist_q <= '0;
    end
    else if (CE)
    begin
      if (state_q == ST_EXEC && op_q == OP_READ && found_q && !none_valid)
      begin
        for (int k = 0; k < 3; k++)
        begin
          comp_q[k] <= part3(cam_word_q[hit_idx_q], k);                           // R05
          mask_q[k] <= part3(cam_mask_q[hit_idx_q], k);
        end
        pers_q <= {{(REG_W-PERS_W){1'b0}}, cam_pers_q[hit_idx_q]};                // R24
      end
      else if (st_done)
      begin
        bist_q <= st_sig;
      end
      else if (REG_WR)
      begin
        case (REG_SEL)
          SEL_COMP0: comp_q[0] <= REG_WDATA;
          SEL_COMP1: comp_q[1] <= REG_WDATA;
          SEL_COMP2: comp_q[2] <= REG_WDATA;
          SEL_MASK0: mask_q[0] <= REG_WDATA;
          SEL_MASK1: mask_q[1] <= REG_WDATA;
          SEL_MASK2: mask_q[2] <= REG_WDATA;
          SEL_PERS:  pers_q    <= REG_WDATA;
          SEL_BIST:  bist_q    <= REG_WDATA;
          default:
          begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Status flags
  // ************************************************************
  // Flags change only on issue, refusal, execute and completion, never on a read
  always_ff @(posedge CORE_CLK or negedge ARST_N)                                // R16
  begin
    if (!ARST_N)
    begin
      done_q    <= 1'b1;
      found_q   <= 1'b0;
      exact_q   <= 1'b0;
      multiple_match_flag_q    <= 1'b0;
      error_q   <= 1'b0;
      stdone_q  <= 1'b0;
      hit_idx_q <= '0;
    end
    else if (CE)
    begin
      if (cmd_refused)
      begin
        error_q <= 1'b1;                                                          // R23
        done_q  <= 1'b1;
      end
      else if (cmd_go)
      begin
        // Issue clears
        done_q   <= 1'b0;                                                         // R15
        found_q  <= found_q;
        multiple_match_flag_q   <= 1'b0;
        exact_q  <= 1'b0;
        stdone_q <= 1'b0;
        case (afc_op_t'(REG_WDATA[INSTRUCTION_CODE_W-1:0]))
          OP_INV_ALL:
          begin
            found_q <= 1'b0;                                                      // R02
            error_q <= 1'b0;
          end
          OP_WRITE:
          begin
            found_q <= 1'b0;                                                      // R03
            error_q <= 1'b0;
          end
          OP_READ:
          begin
            // Found is needed to pick the entry, so read judges it at issue
            error_q <= none_valid || !found_q;                                    // R06
          end
          OP_INV_ONE, OP_SKIP:
          begin
            error_q <= !found_q;                                                  // R12
            found_q <= 1'b0;                                                      // R21
          end
          default:
          begin
            found_q <= 1'b0;                                                      // R15
            error_q <= 1'b0;
          end
        endcase
      end
      else if (state_q == ST_EXEC && op_q == OP_READ)
      begin
        found_q <= 1'b0;                                                          // R15
      end
      else if (state_q == ST_EXEC && op_q == OP_FIND)
      begin
        found_q   <= any_hit;                                                     // R10
        multiple_match_flag_q    <= multi_hit;
        exact_q   <= |dax_vec;
        hit_idx_q <= first_hit;                                                   // R24
      end
      else if (state_q == ST_FINISH)
      begin
        done_q <= 1'b1;                                                           // R17
        if (op_q == OP_SELFTEST)
        begin
          stdone_q <= 1'b1;                                                       // R07
        end
      end
    end
  end

  // ************************************************************
  // Read data and completion output
  // ************************************************************
  logic [REG_W-1:0] status_word;

  // Reserved bits zero, revision in bits 7:5
  assign status_word = {done_q, all_valid, found_q, exact_q, multiple_match_flag_q, error_q,     // R19
                        none_valid, stdone_q, REVISION, 5'h00};

  // Registered read mux, no side effects
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      REG_RDATA <= '0;
    end
    else if (CE && REG_RD)
    begin
      case (REG_SEL)
        SEL_CMD:    REG_RDATA <= {13'h0000, instruction_code_q};                              // R01
        SEL_STATUS: REG_RDATA <= status_word;                                     // R18
        SEL_BIST:   REG_RDATA <= bist_q;
        SEL_PERS:   REG_RDATA <= pers_q;
        SEL_COMP0:  REG_RDATA <= comp_q[0];
        SEL_COMP1:  REG_RDATA <= comp_q[1];
        SEL_COMP2:  REG_RDATA <= comp_q[2];
        SEL_MASK0:  REG_RDATA <= mask_q[0];
        SEL_MASK1:  REG_RDATA <= mask_q[1];
        SEL_MASK2:  REG_RDATA <= mask_q[2];
        default:    REG_RDATA <= '0;
      endcase
    end
  end

  // Completion level for a host interrupt line
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      DONE_IRQ <= 1'b0;
    end
    else if (CE)
    begin
      DONE_IRQ <= (state_q == ST_FINISH) || cmd_refused || (DONE_IRQ && !cmd_go); // R20
    end
  end

endmodule // afc_cam_cmd

/* File: afc_cam_cmd_chk.sv */
// Port checker of the address filter command unit
`timescale 1ns/1ps
module afc_cam_cmd_chk
  import afc_pkg::*;
(
  input wire logic             CORE_CLK,
  input wire logic             ARST_N,
  input wire logic             CE,
  input wire logic             REG_WR,
  input wire logic             REG_RD,
  input wire logic [3:0]       REG_SEL,
  input wire logic [REG_W-1:0] REG_WDATA,
  input wire logic             RX_CMP_BUSY,
  input wire logic [REG_W-1:0] REG_RDATA,
  input wire logic             DONE_IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Command taken while idle, and reads by target
  logic cmd_go;
  logic cmd_rx;
  logic rd_st;
  assign cmd_go = CE && REG_WR && REG_SEL == SEL_CMD && DONE_IRQ && !RX_CMP_BUSY;
  assign cmd_rx = CE && REG_WR && REG_SEL == SEL_CMD && DONE_IRQ && RX_CMP_BUSY;
  assign rd_st  = CE && REG_RD && REG_SEL == SEL_STATUS;
  a_cmd_drops_irq:
    assert property (cmd_go |=> !DONE_IRQ)
    else $error("done held after command");
  a_op_done_soon:
    assert property (cmd_go && REG_WDATA[2:0] != 3'h3 |=> !DONE_IRQ ##[1:3] DONE_IRQ)
    else $error("operation late");
  a_selftest_span:
    assert property (cmd_go && REG_WDATA[2:0] == 3'h3 |=> !DONE_IRQ [*8] ##[50:80] DONE_IRQ)
    else $error("self test span wrong");
  a_refused_done:
    assert property (cmd_rx |=> DONE_IRQ)
    else $error("refused command lost done");
  a_rdata_static:
    assert property (!(CE && REG_RD) |=> $stable(REG_RDATA))
    else $error("read data moved");
  a_status_rsvd:
    assert property (rd_st |=> REG_RDATA[4:0] == 5'h0)
    else $error("status reserved set");
  a_cmd_rsvd:
    assert property (CE && REG_RD && REG_SEL == SEL_CMD |=> REG_RDATA[15:3] == 13'h0)
    else $error("command reserved set");
  a_done_shown:
    assert property (rd_st && DONE_IRQ && !REG_WR |=> REG_RDATA[ST_DONE])
    else $error("done not in status");
  c_selftest: cover property (cmd_go && REG_WDATA[2:0] == 3'h3);
  c_refused: cover property (cmd_rx);
  c_find: cover property (cmd_go && REG_WDATA[2:0] == 3'h4);
endmodule // afc_cam_cmd_chk

bind afc_cam_cmd afc_cam_cmd_chk u_chk (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .CE(CE), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA), .RX_CMP_BUSY(RX_CMP_BUSY),
  .REG_RDATA(REG_RDATA), .DONE_IRQ(DONE_IRQ));

/* File: afc_host_model.sv */
// Node processor model on the host register port
`timescale 1ns/1ps
module afc_host_model
  import afc_pkg::*;
(
  input  wire logic             clk,
  output logic                  reg_wr,
  output logic                  reg_rd,
  output logic      [3:0]       reg_sel,
  output logic      [REG_W-1:0] reg_wdata,
  input  wire logic [REG_W-1:0] reg_rdata
);
  // Idle bus at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 4'h0;
    reg_wdata = 16'h0000;
  end
  // One write strobe; data inverted once released
  task automatic wr(input logic [3:0] sel, input logic [REG_W-1:0] d);
    @(negedge clk);
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // One read strobe; data taken an edge later
  task automatic rd(input logic [3:0] sel, output logic [REG_W-1:0] d);
    @(negedge clk);
    reg_sel = sel;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // Poll done before any further command
  task automatic idle();
    logic [REG_W-1:0] s;
    s = 16'h0000;
    for (int i = 0; i < 100 && s[ST_DONE] !== 1'b1; i++)
      rd(SEL_STATUS, s);
  endtask
  // Issue a command and wait for it
  task automatic cmd(input afc_op_t op);
    wr(SEL_CMD, {13'h0, op});
    idle();
  endtask
endmodule // afc_host_model

/* File: tb_addr_filter_cam_command_unit.sv */
// Self-checking testbench of the address filter command unit
`timescale 1ns/1ps
module tb_addr_filter_cam_command_unit
  import afc_pkg::*;
;
  logic             core_clk;
  logic             arst_n;
  logic             ce;
  logic             reg_wr;
  logic             reg_rd;
  logic [3:0]       reg_sel;
  logic [REG_W-1:0] reg_wdata;
  logic             rx_cmp_busy;
  logic [REG_W-1:0] reg_rdata;
  logic             done_irq;
  logic [REG_W-1:0] v;
  int               n_fail;
  int               check_count;
  int               cycles;
  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  afc_cam_cmd u_dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .CE(ce), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .RX_CMP_BUSY(rx_cmp_busy), .REG_RDATA(reg_rdata),
    .DONE_IRQ(done_irq));
  afc_host_model u_host (.clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic st(input logic [REG_W-1:0] exp);
    u_host.rd(SEL_STATUS, v);
    chk(v, exp);
  endtask
  task automatic rst();
    arst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    ce = 1'b1;
    rx_cmp_busy = 1'b0;
    rst();
    st(16'h8220);
    u_host.wr(SEL_PERS, 16'h0004);
    u_host.wr(SEL_MASK0, 16'hffff);
    u_host.wr(SEL_MASK1, 16'hffff);
    u_host.wr(SEL_MASK2, 16'hffff);
    for (int i = 0; i < ENTRIES; i++)
    begin
      u_host.wr(SEL_COMP0, 16'(i / 2));
      u_host.cmd(OP_WRITE);
      if (i == 0)
        st(16'h8020);
    end
    st(16'hc020);
    chk({15'h0, done_irq}, 16'h0001);
    u_host.wr(SEL_COMP0, 16'h00aa);
    u_host.cmd(OP_WRITE);
    st(16'hc020);
    u_host.cmd(OP_FIND);
    st(16'hc020);
    $display("test fill finished");
    u_host.wr(SEL_COMP0, 16'h0005);
    u_host.cmd(OP_FIND);
    st(16'hf820);
    u_host.wr(SEL_COMP0, 16'h1234);
    u_host.cmd(OP_READ);
    st(16'hc020);
    u_host.rd(SEL_COMP0, v);
    chk(v, 16'h0005);
    u_host.rd(SEL_PERS, v);
    chk(v, 16'h0005);
    u_host.cmd(OP_FIND);
    u_host.cmd(OP_SKIP);
    st(16'hc020);
    u_host.cmd(OP_FIND);
    st(16'hf020);
    u_host.cmd(OP_INV_ONE);
    st(16'h8020);
    u_host.cmd(OP_INV_ONE);
    st(16'h8420);
    u_host.cmd(OP_CLR_SKIP);
    st(16'h8020);
    u_host.cmd(OP_FIND);
    st(16'hb020);
    $display("test find finished");
    u_host.cmd(OP_INV_ALL);
    st(16'h8220);
    rx_cmp_busy = 1'b1;
    u_host.cmd(OP_FIND);
    rx_cmp_busy = 1'b0;
    st(16'h8620);
    u_host.rd(SEL_CMD, v);
    chk(v, 16'h0004);
    u_host.cmd(OP_READ);
    st(16'h8620);
    $display("test errors finished");
    u_host.wr(SEL_CMD, {13'h0, OP_SELFTEST});
    u_host.wr(SEL_CMD, 16'h0000);
    u_host.idle();
    u_host.rd(SEL_STATUS, v);
    chk(v & 16'h8000, 16'h8000);
    chk(v & 16'h0100, 16'h0100);
    u_host.rd(SEL_CMD, v);
    chk(v, 16'h0000);
    rst();
    st(16'h8220);
    $display("test selftest finished");
    summarize();
  end
endmodule // tb_addr_filter_cam_command_unit
